// file: dtiu_pkg.sv
// package for the dead-time insertion unit: register map, fields, types
// assumes a 32-bit apb slave and one peripheral clock
package dtiu_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h70;
    localparam logic [7:0] OFS_TIME = 8'h74;
    localparam logic [7:0] OFS_FC = 8'h78;
    localparam logic [7:0] OFS_OGEN = 8'h7C;
    localparam logic [7:0] OFS_FSTAT = 8'h80;
    localparam logic [7:0] OFS_FCLR = 8'h84;
    localparam logic [7:0] OFS_LOCK = 8'h88;
    localparam logic [7:0] OFS_ROUTE = 8'h28;
    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_DAS = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_CINV = 3;
    localparam int CTRL_ESEN = 24;
    localparam int CTRL_ESSEL = 4;
    // timing fields
    localparam int TIME_PRESC = 0;
    localparam int TIME_RISE = 8;
    localparam int TIME_FALL = 16;
    // fault configuration fields
    localparam int FC_EV0SEL = 0;
    localparam int FC_EV1SEL = 8;
    localparam int FC_ACT = 16;
    localparam int FC_SRCEN = 24;
    // fault source bits
    localparam int FS_EV0 = 0;
    localparam int FS_EV1 = 1;
    localparam int FS_DBG = 2;
    localparam int FS_LOCKUP = 3;
    // fault actions
    localparam logic [1:0] ACT_INACTIVE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_TRISTATE = 2'h2;
    localparam logic [15:0] UNLOCK_KEY = 16'hCE80;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef struct packed {
        logic [2:0] primary;
        logic [2:0] complement;
    } dtiu_pins_t;
endpackage

// file: dtiu_top.sv
// dead-time insertion unit with apb register slave
// assumes compare inputs and event channels synchronous to pclk
`timescale 1ns/1ns
`default_nettype none
// Function
// - disabled unit passes compare outputs unchanged
// - three pairs, primaries replace compare outputs
// - rising edges of both outputs delayed
// - separate rise and fall delays, shared
// - shared prescaler divides 1 to 1024
// - dead-times accept 1 to 64 counts
// - pair never both active together, except low fault action with base polarity set and complement invert clear
// - base polarity inverts both outputs
// - complement invert flips complementaries only
// - per-output enable forces inactive level
// - event channel may drive pair zero
// - event source error within prescale step
// - four selectable fault sources, two selectors
// - fault sets status bit, forces safe
// - safe state inactive, low or tristate
// - inactive action follows output polarity
// - status bits match source enable layout
// - auto restart clears debug flag
// - fault exits only when all clear
// - lock write without the key blocks protected writes
// - lock reads one when locked
module dtiu_top #(
    parameter int N_EVENT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] compare_in,
    input wire logic [N_EVENT-1:0] event_channels,
    input wire logic debug_halted,
    input wire logic core_lockup,
    output dtiu_pkg::dtiu_pins_t pins_out,
    output dtiu_pkg::dtiu_pins_t pins_oe,
    output logic [31:0] pin_routing_out
);
    initial begin
        if (N_EVENT < 1 || N_EVENT > 256) begin
            $error("N_EVENT out of range");
        end
    end

    logic [31:0] ctrl_r, time_r, fc_r, ogen_r, route_r;
    logic [3:0] fstat_r;
    logic lock_r;
    logic [9:0] pre_cnt_r;
    logic tick;
    logic wr, rd;
    logic [3:0] prescale;
    logic [5:0] rise_t, fall_t;
    logic [2:0] src;
    logic [2:0] src_d_r;
    logic [6:0] cnt_r [3];
    logic [2:0] pri_r, cmp_r;
    logic in_fault;
    logic [3:0] fault_hit;
    logic dbg_d_r;
    logic [3:0] clr_mask;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign prescale = time_r[dtiu_pkg::TIME_PRESC +: 4];
    assign rise_t = time_r[dtiu_pkg::TIME_RISE +: 6];
    assign fall_t = time_r[dtiu_pkg::TIME_FALL +: 6];
    assign in_fault = |fstat_r;

    // source select, event may drive pair zero
    always_comb begin
        src = compare_in;
        if (ctrl_r[dtiu_pkg::CTRL_ESEN]) begin
            src[0] = event_channels[ctrl_r[dtiu_pkg::CTRL_ESSEL +: 8]
                % N_EVENT];
        end
    end

    // register writes, lock gated except output enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= dtiu_pkg::RESET_WORD;
            time_r <= dtiu_pkg::RESET_WORD;
            fc_r <= dtiu_pkg::RESET_WORD;
            ogen_r <= dtiu_pkg::RESET_WORD;
            route_r <= dtiu_pkg::RESET_WORD;
        end else if (wr) begin
            if (!lock_r) begin
                unique case (paddr)
                    dtiu_pkg::OFS_CTRL: ctrl_r <= pwdata;
                    dtiu_pkg::OFS_TIME: time_r <= pwdata;
                    dtiu_pkg::OFS_FC: fc_r <= pwdata;
                    dtiu_pkg::OFS_ROUTE: route_r <= pwdata;
                    default: ;
                endcase
            end
            if (paddr == dtiu_pkg::OFS_OGEN) begin
                ogen_r <= {26'h0, pwdata[5:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (wr && paddr == dtiu_pkg::OFS_LOCK) begin
            lock_r <= (pwdata[15:0] != dtiu_pkg::UNLOCK_KEY);
        end
    end

    // fault detection and status
    always_comb begin
        fault_hit = 4'h0;
        fault_hit[dtiu_pkg::FS_EV0] = event_channels[
            fc_r[dtiu_pkg::FC_EV0SEL +: 8] % N_EVENT];
        fault_hit[dtiu_pkg::FS_EV1] = event_channels[
            fc_r[dtiu_pkg::FC_EV1SEL +: 8] % N_EVENT];
        fault_hit[dtiu_pkg::FS_DBG] = debug_halted;
        fault_hit[dtiu_pkg::FS_LOCKUP] = core_lockup;
        fault_hit = fault_hit & fc_r[dtiu_pkg::FC_SRCEN +: 4];
        clr_mask = 4'h0;
        if (wr && paddr == dtiu_pkg::OFS_FCLR) begin
            clr_mask = pwdata[3:0];
        end
        if (ctrl_r[dtiu_pkg::CTRL_DAS] && dbg_d_r && !debug_halted) begin
            clr_mask[dtiu_pkg::FS_DBG] = 1'b1;
        end
    end

    // set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fstat_r <= 4'h0;
            dbg_d_r <= 1'b0;
        end else begin
            dbg_d_r <= debug_halted;
            fstat_r <= (fstat_r & ~clr_mask) | fault_hit;
        end
    end

    // shared prescaler, tick every 2^prescale cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r <= 10'h0;
        end else if (tick) begin
            pre_cnt_r <= 10'h0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 10'h1;
        end
    end
    // prescale codes above ten clamp to 1024
    assign tick = (prescale >= 4'hA) ? (pre_cnt_r == 10'h3FF) :
        (pre_cnt_r == 10'((11'h1 << prescale) - 11'h1));

    // per-channel dead-time generation
    for (genvar i = 0; i < 3; i++) begin : g_ch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r[i] <= 7'h0;
                pri_r[i] <= 1'b0;
                cmp_r[i] <= 1'b0;
                src_d_r[i] <= 1'b0;
            end else begin
                src_d_r[i] <= src[i];
                if (src[i] != src_d_r[i]) begin
                    // edge: both inactive, reload delay
                    pri_r[i] <= 1'b0;
                    cmp_r[i] <= 1'b0;
                    cnt_r[i] <= src[i] ? {1'b0, rise_t} + 7'h1 :
                        {1'b0, fall_t} + 7'h1;
                end else if (cnt_r[i] != 7'h0) begin
                    // count in prescaled ticks, error within one step
                    if (tick) begin
                        cnt_r[i] <= cnt_r[i] - 7'h1;
                    end
                end else begin
                    pri_r[i] <= src[i];
                    cmp_r[i] <= !src[i];
                end
            end
        end
    end

    // output stage: polarity, enables, fault action
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_out <= '0;
            pins_oe <= '0;
        end else begin
            logic pol;
            logic cpol;
            logic [2:0] po, co;
            pol = ctrl_r[dtiu_pkg::CTRL_POL];
            cpol = pol ^ ctrl_r[dtiu_pkg::CTRL_CINV];
            if (!ctrl_r[dtiu_pkg::CTRL_EN]) begin
                pins_out.primary <= compare_in;
                pins_out.complement <= 3'h0;
                pins_oe.primary <= 3'h7;
                pins_oe.complement <= 3'h0;
            end else begin
                // active level xor polarity
                po = (pri_r & ogen_r[2:0]) ^ {3{pol}};
                co = (cmp_r & ogen_r[5:3]) ^ {3{cpol}};
                pins_oe.primary <= 3'h7;
                pins_oe.complement <= 3'h7;
                if (in_fault) begin
                    unique case (fc_r[dtiu_pkg::FC_ACT +: 2])
                        dtiu_pkg::ACT_LOW: begin
                            po = 3'h0;
                            co = 3'h0;
                        end
                        dtiu_pkg::ACT_TRISTATE: begin
                            pins_oe.primary <= 3'h0;
                            pins_oe.complement <= 3'h0;
                        end
                        default: begin
                            po = {3{pol}};
                            co = {3{cpol}};
                        end
                    endcase
                end
                pins_out.primary <= po;
                pins_out.complement <= co;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_routing_out <= dtiu_pkg::RESET_WORD;
        end else begin
            pin_routing_out <= route_r;
        end
    end

    // apb read path and ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= dtiu_pkg::RESET_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd) begin
                unique case (paddr)
                    dtiu_pkg::OFS_CTRL: prdata <= ctrl_r;
                    dtiu_pkg::OFS_TIME: prdata <= time_r;
                    dtiu_pkg::OFS_FC: prdata <= fc_r;
                    dtiu_pkg::OFS_OGEN: prdata <= ogen_r;
                    dtiu_pkg::OFS_FSTAT: prdata <= {28'h0, fstat_r};
                    dtiu_pkg::OFS_LOCK: prdata <= {31'h0, lock_r};
                    dtiu_pkg::OFS_ROUTE: prdata <= route_r;
                    dtiu_pkg::OFS_FCLR: prdata <= dtiu_pkg::RESET_WORD;
                    default: prdata <= dtiu_pkg::RESET_WORD;
                endcase
                if (!(paddr inside {dtiu_pkg::OFS_CTRL, dtiu_pkg::OFS_TIME,
                    dtiu_pkg::OFS_FC, dtiu_pkg::OFS_OGEN,
                    dtiu_pkg::OFS_FSTAT, dtiu_pkg::OFS_FCLR,
                    dtiu_pkg::OFS_LOCK, dtiu_pkg::OFS_ROUTE})) begin
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable && !(paddr inside {
                dtiu_pkg::OFS_CTRL, dtiu_pkg::OFS_TIME, dtiu_pkg::OFS_FC,
                dtiu_pkg::OFS_OGEN, dtiu_pkg::OFS_FSTAT, dtiu_pkg::OFS_FCLR,
                dtiu_pkg::OFS_LOCK, dtiu_pkg::OFS_ROUTE})) begin
                pslverr <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: dtiu_sva.sv
// port assertions for the dead-time unit
// assumes one access cycle per apb transfer
`timescale 1ns/1ns
`default_nettype none
module dtiu_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] compare_in,
    input wire logic core_lockup,
    input wire dtiu_pkg::dtiu_pins_t pins_out,
    input wire dtiu_pkg::dtiu_pins_t pins_oe
);
    logic en_c, pol_c, lock_c, wr_c, cinv_c;
    logic [3:0] fsen_c;
    logic [1:0] act_c, age_c;
    logic [5:0] ogen_c;
    assign wr_c = psel && penable && pwrite;
    // shadow of the register state seen on the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_c, pol_c, lock_c, fsen_c, act_c} <= 9'h000;
            ogen_c <= 6'h3F;
            age_c <= 2'h0;
            cinv_c <= 1'b0;
        end else begin
            age_c <= wr_c ? 2'h0 : age_c + {1'b0, age_c != 2'h3};
            if (wr_c && paddr == dtiu_pkg::OFS_LOCK)
                lock_c <= pwdata[15:0] != dtiu_pkg::UNLOCK_KEY;
            if (wr_c && paddr == dtiu_pkg::OFS_OGEN)
                ogen_c <= pwdata[5:0];
            if (wr_c && !lock_c && paddr == dtiu_pkg::OFS_CTRL)
                {cinv_c, pol_c, en_c} <= {pwdata[3], pwdata[2], pwdata[0]};
            if (wr_c && !lock_c && paddr == dtiu_pkg::OFS_FC)
                {fsen_c, act_c} <= {pwdata[27:24], pwdata[17:16]};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_LOCK: assert property (pready && !pwrite && paddr ==
        dtiu_pkg::OFS_LOCK |-> prdata == {31'h0, lock_c})
        else $error("lock readback wrong");
    AST_PASS: assert property (age_c[1] && !en_c && fsen_c == 4'h0
        |-> pins_out.primary == $past(compare_in) && pins_oe.primary == 3'h7)
        else $error("disabled unit not transparent");
    AST_NOSHOOT: assert property (age_c[1] && en_c && fsen_c == 4'h0 |->
        ((pins_out.primary ^ {3{pol_c}}) &
        (pins_out.complement ^ {3{pol_c ^ cinv_c}})
        & pins_oe.primary & pins_oe.complement) == 3'h0)
        else $error("pair both active");
    AST_OGEN: assert property (age_c[1] && en_c && fsen_c == 4'h0
        |-> (pins_out.primary & ~ogen_c[2:0]) == ({3{pol_c}} & ~ogen_c[2:0]))
        else $error("disabled output not inactive");
    AST_FLT_INACT: assert property (age_c[1] && en_c && fsen_c[3] &&
        act_c == dtiu_pkg::ACT_INACTIVE && core_lockup
        |-> ##2 pins_out.primary == {3{pol_c}})
        else $error("fault not at inactive level");
    AST_FLT_TRI: assert property (age_c[1] && en_c && fsen_c[3] &&
        act_c == dtiu_pkg::ACT_TRISTATE && core_lockup |-> ##2 pins_oe == 6'h00)
        else $error("fault not tristated");
endmodule
`default_nettype wire

// file: dtiu_gate_drv.sv
// half-bridge gate driver model, flags shoot-through
// assumes active-high gates while armed
`timescale 1ns/1ns
`default_nettype none
module dtiu_gate_drv (
    input wire logic pclk,
    input wire logic arm,
    input wire dtiu_pkg::dtiu_pins_t pins,
    input wire dtiu_pkg::dtiu_pins_t oe,
    output logic shoot
);
    always_ff @(posedge pclk) begin
        shoot <= arm && |(pins.primary & pins.complement & oe.primary
            & oe.complement);
    end
endmodule
`default_nettype wire

// file: dead_time_insertion_unit_tb_top.sv
// random and corner stimulus for the dead-time unit over apb
// assumes checker and gate model compiled before
`timescale 1ns/1ns
`default_nettype none
module dead_time_insertion_unit_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, debug_halted = 1'b0, core_lockup = 1'b0;
    logic arm = 1'b1, pready, pslverr, shoot, ok;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, route_o;
    logic [2:0] compare_in = 3'h0;
    logic [15:0] event_channels = 16'h0;
    logic [5:0] pv;
    dtiu_pkg::dtiu_pins_t pins_out, pins_oe;
    int mismatches = 0, comparisons = 0, d0, d1, p, r, f, j;
    assign pv = pins_out;
    always #25 pclk = ~pclk;
    dtiu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_in(compare_in), .event_channels(event_channels),
        .debug_halted(debug_halted), .core_lockup(core_lockup),
        .pins_out(pins_out), .pins_oe(pins_oe), .pin_routing_out(route_o));
    dtiu_gate_drv gate_u (.pclk(pclk), .arm(arm), .pins(pins_out),
        .oe(pins_oe), .shoot(shoot));
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) mismatches++;
        rd = pslverr ? 32'hDEAD : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_hi(input int b, output int n);
        n = 0;
        while (n < 300 && pv[b] !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic final_report;
        $display("compares %0d bad %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) if (shoot === 1'b1) mismatches++;
    initial begin
        #(50 * 30000);
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(32'h5A2A1864));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, dtiu_pkg::OFS_LOCK, 32'h0);
        chk("lock_rst", 32'h0, rd);
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped", 32'hDEAD, rd);
        repeat (20) begin
            @(posedge pclk);
            compare_in <= 3'($urandom);
        end
        chk("comp_oe", 32'h0, 32'(pins_oe.complement));
        $display("passthrough done");
        apb(1'b1, dtiu_pkg::OFS_OGEN, 32'h3F);
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h1);
        for (int k = 0; k < 4; k++) begin
            p = k < 2 ? 0 : 2;
            r = k == 0 ? 63 : $urandom_range(0, 20);
            f = k == 1 ? 0 : $urandom_range(0, 20);
            apb(1'b1, dtiu_pkg::OFS_TIME, 32'((f << 16) | (r << 8) | p));
            compare_in <= 3'h0;
            repeat (300) @(posedge pclk);
            compare_in <= 3'h1;
            wait_hi(3, d0);
            repeat (300) @(posedge pclk);
            compare_in <= 3'h0;
            wait_hi(0, d1);
            ok = d0 >= (r + 1) << p && d0 <= ((r + 1) << p) + (1 << p) + 3;
            chk("rise_dly", 32'h1, 32'(ok));
            if (p == 0) chk("rise_fall", 32'(r - f), 32'(d0 - d1));
        end
        chk("comp_oe_on", 32'h7, 32'(pins_oe.complement));
        $display("deadtime done");
        apb(1'b1, dtiu_pkg::OFS_OGEN, 32'($urandom_range(0, 63)));
        repeat (30) begin
            @(posedge pclk);
            compare_in <= 3'($urandom);
        end
        apb(1'b1, dtiu_pkg::OFS_OGEN, 32'h3F);
        arm <= 1'b0;
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h5);
        compare_in <= 3'h7;
        repeat (300) @(posedge pclk);
        chk("pol_low", 32'h0, 32'(pins_out.primary));
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h9);
        repeat (300) @(posedge pclk);
        chk("cinv_comp", 32'h3F, 32'(pv));
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h1);
        compare_in <= 3'h0;
        repeat (300) @(posedge pclk);
        arm <= 1'b1;
        j = $urandom_range(0, 15);
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h0100_0001 | 32'(j << 4));
        repeat (300) @(posedge pclk);
        event_channels[j] <= 1'b1;
        wait_hi(3, d0);
        chk("event_src", 32'h1, 32'(d0 < 300));
        chk("other_pair", 32'h0, 32'(pins_out.primary[2:1]));
        event_channels <= 16'h0;
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h1);
        compare_in <= 3'h7;
        $display("output modes done");
        for (int a = 0; a < 3; a++) begin
            apb(1'b1, dtiu_pkg::OFS_FC, 32'h0800_0000 | 32'(a << 16));
            repeat (3) @(posedge pclk);
            core_lockup <= 1'b1;
            repeat (4) @(posedge pclk);
            core_lockup <= 1'b0;
            apb(1'b0, dtiu_pkg::OFS_FSTAT, 32'h0);
            chk("fstat_lk", 32'h8, rd);
            apb(1'b1, dtiu_pkg::OFS_FCLR, 32'hF);
        end
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h3);
        apb(1'b1, dtiu_pkg::OFS_FC, 32'h0500_0000 | 32'(j));
        event_channels[j] <= 1'b1;
        debug_halted <= 1'b1;
        repeat (3) @(posedge pclk);
        event_channels <= 16'h0;
        debug_halted <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, dtiu_pkg::OFS_FSTAT, 32'h0);
        chk("fstat_ev", 32'h1, rd);
        chk("still_safe", 32'h0, 32'(pins_out.primary));
        apb(1'b1, dtiu_pkg::OFS_FCLR, 32'h1);
        apb(1'b0, dtiu_pkg::OFS_FSTAT, 32'h0);
        chk("fstat_clr", 32'h0, rd);
        apb(1'b1, dtiu_pkg::OFS_FC, 32'h0);
        $display("fault done");
        apb(1'b1, dtiu_pkg::OFS_LOCK, 32'(dtiu_pkg::UNLOCK_KEY) + 32'h1);
        apb(1'b0, dtiu_pkg::OFS_LOCK, 32'h0);
        chk("lock_set", 32'h1, rd);
        apb(1'b1, dtiu_pkg::OFS_CTRL, 32'h0);
        apb(1'b0, dtiu_pkg::OFS_CTRL, 32'h0);
        chk("ctrl_held", 32'h1, 32'(rd[0]));
        apb(1'b1, dtiu_pkg::OFS_ROUTE, 32'hA5);
        apb(1'b0, dtiu_pkg::OFS_ROUTE, 32'h0);
        chk("route_held", 32'h0, rd);
        apb(1'b1, dtiu_pkg::OFS_LOCK, 32'(dtiu_pkg::UNLOCK_KEY));
        apb(1'b0, dtiu_pkg::OFS_LOCK, 32'h0);
        chk("lock_clr", 32'h0, rd);
        apb(1'b1, dtiu_pkg::OFS_ROUTE, 32'hA5);
        repeat (2) @(posedge pclk);
        chk("route_out", 32'hA5, route_o);
        $display("lock done");
        final_report();
    end
endmodule
bind dtiu_top dtiu_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_in(compare_in), .core_lockup(core_lockup),
    .pins_out(pins_out), .pins_oe(pins_oe));
`default_nettype wire
